// ===== inc/dmc_chan_if.sv
`timescale 1ns/10ps
interface dmc_chan_if;
	logic channel_transfer_enable;
	logic master_transfer_enable;
	logic full;
	logic blk;
	logic bsz_first;
	logic bsz_last;
	logic tc_last;
	logic step;
	logic master_transfer_enable_clr;
	logic dte_clr;
	logic flag_clr;
	logic src_block;
	logic xfer_req;

	modport ctl (
		output channel_transfer_enable, master_transfer_enable, full, blk, bsz_first, bsz_last, tc_last,
		input step, master_transfer_enable_clr, dte_clr, flag_clr, src_block, xfer_req
	);
	modport eng (
		input channel_transfer_enable, master_transfer_enable, full, blk, bsz_first, bsz_last, tc_last,
		output step, master_transfer_enable_clr, dte_clr, flag_clr, src_block, xfer_req
	);
endinterface : dmc_chan_if

// ===== inc/dmc_pkg.sv
package dmc_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NPAIR = 2;
	localparam int NCHAN = 4;
	localparam int AW = 24;
	localparam int TCW = 16;
	localparam int BSW = 8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] OFS_CTRL_A = 4'h0;
	localparam logic [3:0] OFS_CTRL_B = 4'h1;
	localparam logic [3:0] OFS_MAR_EXT = 4'h4;
	localparam logic [3:0] OFS_MAR_HI = 4'h5;
	localparam logic [3:0] OFS_MAR_MID = 4'h6;
	localparam logic [3:0] OFS_MAR_LO = 4'h7;
	localparam logic [3:0] OFS_TC_HI = 4'h8;
	localparam logic [3:0] OFS_TC_LO = 4'h9;
	localparam logic [3:0] OFS_BSZ_CNT = 4'ha;
	localparam logic [3:0] OFS_BSZ_INIT = 4'hb;
	localparam logic [7:0] REG_MODE = 8'h20;
	localparam logic [7:0] REG_IRQ_STAT = 8'h21;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_DTE = 0;
	localparam int BIT_DIE = 1;
	localparam int BIT_FULL = 2;
	localparam int BIT_BLK = 3;
	localparam int BIT_WORD = 4;
	localparam int BIT_MASTER_TRANSFER_ENABLE = 2;
	localparam int BIT_MODE16M = 0;

	// ----------------------------------------
	// Reset values and constants
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [AW-1:0] MAR_RST = 24'h000000;
	localparam logic [TCW-1:0] TC_RST = 16'h0000;
	localparam logic [BSW-1:0] BSZ_RST = 8'h00;
	localparam logic [AW-1:0] MASK_1M = 24'h0fffff;
	localparam logic [AW-1:0] STEP_BYTE = 24'h000001;
	localparam logic [AW-1:0] STEP_WORD = 24'h000002;

	typedef enum logic {
		DMC_IDLE = 1'b0,
		DMC_PEND = 1'b1
	} dmc_pst_e;

endpackage : dmc_pkg

// ===== sim/dmc_xfer_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bus engine model: acks one unit at a time
// ----------------------------------------
module dmc_xfer_partner import dmc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Transfer handshake
	input wire logic [NPAIR-1:0] xfer_req,
	input wire logic [NPAIR-1:0] dead,
	input wire logic [NPAIR-1:0] slow,
	output logic [NPAIR-1:0] xfer_ack
);
	logic [NPAIR-1:0] gen_r;
	logic [NPAIR-1:0][1:0] cnt_r;

	// A gap cycle follows each ack, since the request only drops one cycle later.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gen_r <= '0;
			cnt_r <= '0;
		end else begin
			for (int p = 0; p < NPAIR; p++) begin
				gen_r[p] <= 1'b0;
				if (xfer_req[p] && !gen_r[p]) begin
					if (!slow[p] || cnt_r[p] == 2'h3) begin
						gen_r[p] <= 1'b1;
						cnt_r[p] <= 2'h0;
					end else begin
						cnt_r[p] <= cnt_r[p] + 2'h1;
					end
				end
			end
		end
	end

	// Dead acks arrive outside a request and must change nothing.
	// The model only acknowledges; it never aims a unit at this block or outside the I/O page.
	assign xfer_ack = gen_r | dead;
endmodule : dmc_xfer_partner

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top import dmc_pkg::*;;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic nmi = 1'b0;
	logic [NPAIR-1:0] act_req = '0;
	logic [NPAIR-1:0] dead = '0;
	logic [NPAIR-1:0] act_flag_clr, src_irq_block, xfer_req, xfer_ack;
	logic [NPAIR-1:0][AW-1:0] mem_addr;
	logic e0a, e0b, e1a, e1b, eany;
	logic [1:0] etop;
	int n_fail = 0;
	int checked = 0;
	logic [7:0] t_a [10] = '{8'h00, 8'h11, 8'h00, 8'h10, 8'h01, 8'h01, 8'h10, 8'h10, 8'h11, 8'h01};
	logic [7:0] t_d [10] = '{8'h02, 8'h02, 8'h00, 8'h02, 8'h06, 8'h03, 8'h06, 8'h00, 8'h00, 8'h00};
	logic [6:0] t_e [10] = '{7'h44, 7'h64, 7'h63, 7'h72, 7'h79, 7'h72, 7'h52, 7'h63, 7'h03, 7'h03};

	always #2.5 clock = ~clock;

	dmc_top dmc_top_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi(nmi), .act_req(act_req),
		.act_flag_clr(act_flag_clr), .src_irq_block(src_irq_block), .xfer_req(xfer_req),
		.xfer_ack(xfer_ack), .mem_addr(mem_addr), .end_irq_ch0_a(e0a), .end_irq_ch0_b(e0b),
		.end_irq_ch1_a(e1a), .end_irq_ch1_b(e1b), .end_irq_top(etop), .end_irq_any(eany));

	// Pair 1 is served slowly so an NMI can land between two units.
	dmc_xfer_partner dmc_xfer_partner_inst (.clock(clock), .reset_n(reset_n), .xfer_req(xfer_req),
		.dead(dead), .slow(2'b10), .xfer_ack(xfer_ack));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	task automatic act(input int p);
		@(posedge clock);
		act_req[p] <= 1'b1;
		@(posedge clock);
		act_req[p] <= 1'b0;
		#1;
	endtask : act

	task automatic wait_done(input int p);
		int i;
		#1;
		for (i = 0; i < 200 && xfer_req[p] !== 1'b0; i++) begin
			@(posedge clock);
			#1;
		end
		chk(xfer_req[p], 1'b0);
	endtask : wait_done

	task automatic final_report;
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int i;
		int n;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		chk({eany, e1b, e1a, e0b, e0a, etop}, 7'h03);
		rd(8'h00, 8'h00);
		for (i = 0; i < 10; i++) begin
			wr(t_a[i], t_d[i]);
			#1;
			chk({eany, e1b, e1a, e0b, e0a, etop}, t_e[i]);
			if (i == 4) begin
				rd(REG_IRQ_STAT, 8'h5e);
			end
		end
		wr(8'h05, 8'hf3);
		wr(8'h07, 8'h10);
		#1;
		chk(mem_addr[0], 24'h030010);
		wr(REG_MODE, 8'h01);
		#1;
		chk(mem_addr[0], 24'hf30010);
		wr(REG_MODE, 8'h00);
		wr(8'h05, 8'h00);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h00);
		rd(8'h0c, 8'h00);
		// Full mode, two units, then the end request.
		wr(8'h09, 8'h02);
		wr(8'h01, 8'h04);
		wr(8'h00, 8'h07);
		act(0);
		chk(xfer_req[0], 1'b1);
		wait_done(0);
		chk({e0a, mem_addr[0]}, {1'b0, 24'h000011});
		act(0);
		wait_done(0);
		chk({e0a, mem_addr[0]}, {1'b1, 24'h000012});
		rd(8'h00, 8'h06);
		rd(8'h09, 8'h00);
		@(posedge clock);
		dead[0] <= 1'b1;
		@(posedge clock);
		dead[0] <= 1'b0;
		#1;
		chk(mem_addr[0], 24'h000012);
		// Enabled but master clear: halted, source blocked, requests dropped.
		wr(8'h09, 8'h01);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h07);
		#1;
		chk({src_irq_block[0], e0a}, 2'b10);
		act(0);
		chk(xfer_req[0], 1'b0);
		wr(8'h01, 8'h04);
		repeat (3) @(posedge clock);
		#1;
		chk({src_irq_block[0], xfer_req[0]}, 2'b00);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h06);
		#1;
		chk(src_irq_block[0], 1'b0);
		// Block of four on pair 1, broken by NMI after two units.
		wr(8'h16, 8'h01);
		wr(8'h19, 8'h01);
		wr(8'h1b, 8'h04);
		wr(8'h1a, 8'h04);
		wr(8'h11, 8'h04);
		wr(8'h10, 8'h0f);
		act(1);
		n = 0;
		for (i = 0; i < 100 && n < 2; i++) begin
			@(posedge clock);
			#1;
			if (xfer_ack[1] === 1'b1) begin
				n++;
			end
		end
		chk(n, 2);
		@(posedge clock);
		nmi <= 1'b1;
		#1;
		chk(act_flag_clr[1], 1'b1);
		@(posedge clock);
		nmi <= 1'b0;
		#1;
		chk({xfer_req[1], src_irq_block[1], act_flag_clr[1]}, 3'b010);
		rd(8'h11, 8'h00);
		rd(8'h1a, 8'h02);
		chk(mem_addr[1], 24'h000102);
		act(1);
		chk(xfer_req[1], 1'b0);
		wr(8'h11, 8'h04);
		act(1);
		wait_done(1);
		chk({e1a, mem_addr[1]}, {1'b1, 24'h000104});
		rd(8'h1a, 8'h04);
		rd(8'h10, 8'h0e);
		// Word units step the address by two from an even start.
		wr(8'h01, 8'h04);
		wr(8'h00, 8'h17);
		act(0);
		wait_done(0);
		chk({e0a, mem_addr[0]}, {1'b1, 24'h000014});
		final_report;
	end

	initial begin
		#50000;
		n_fail++;
		final_report;
	end
endmodule : tb_top

// ===== src/dmc_end_irq.sv
`timescale 1ns/10ps
module dmc_end_irq import dmc_pkg::*; (
	// Channel state
	input wire logic [NCHAN-1:0] channel_transfer_enable,
	input wire logic [NCHAN-1:0] die,
	input wire logic [NPAIR-1:0] full,
	// Requests
	output logic [NCHAN-1:0] irq,
	output logic [1:0] top,
	output logic any
);

	// ----------------------------------------
	// Per-channel request
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < NCHAN; c++) begin : g_ch
			if (c % 2 == 1) begin : g_b
				assign irq[c] = !channel_transfer_enable[c] && die[c] && !full[c/2];
			end else begin : g_a
				assign irq[c] = !channel_transfer_enable[c] && die[c];
			end
		end
	endgenerate

	// ----------------------------------------
	// Priority
	// ----------------------------------------
	always_comb begin
		top = 2'h3;
		if (irq[0]) begin
			top = 2'h0;
		end else if (irq[1]) begin
			top = 2'h1;
		end else if (irq[2]) begin
			top = 2'h2;
		end
	end

	assign any = |irq;

endmodule : dmc_end_irq

// ===== src/dmc_pair.sv
`timescale 1ns/10ps
module dmc_pair import dmc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Activation and bus engine
	input wire logic act_req,
	input wire logic xfer_ack,
	input wire logic nmi,
	// Pair control
	dmc_chan_if.eng c
);

	dmc_pst_e st_r;
	dmc_pst_e st_nxt;
	logic active;
	logic nmi_hit;

	// ----------------------------------------
	// Request state
	// ----------------------------------------
	// Requests seen while halted are simply dropped, never remembered.
	assign active = c.channel_transfer_enable && c.master_transfer_enable && c.full;
	assign nmi_hit = nmi && c.full && c.master_transfer_enable;

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			DMC_IDLE: begin
				if (active && act_req && !nmi) begin
					st_nxt = DMC_PEND;
				end
			end
			DMC_PEND: begin
				if (!active || nmi_hit) begin
					st_nxt = DMC_IDLE;
				end else if (c.step && (!c.blk || c.bsz_last)) begin
					st_nxt = DMC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= DMC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs to the register side
	// ----------------------------------------
	// An acknowledge that lands after the halt is a dead cycle and moves nothing.
	assign c.xfer_req = (st_r == DMC_PEND) && active;
	assign c.step = c.xfer_req && xfer_ack;
	assign c.master_transfer_enable_clr = nmi_hit;
	assign c.flag_clr = nmi_hit && (st_r == DMC_PEND) && c.blk && !c.bsz_first;
	assign c.dte_clr = c.step && c.tc_last && (!c.blk || c.bsz_last);
	assign c.src_block = c.full && c.channel_transfer_enable && !c.master_transfer_enable;

endmodule : dmc_pair

// ===== src/dmc_top.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - Only end-of-transfer interrupts; one request line per channel 0A, 0B, 1A, 1B.
// - Channel 0 outranks channel 1; A outranks B.
// - Request stands whenever transfer enable is 0 and end-interrupt enable is 1, except on a B channel in full mode.
// - In full address mode the B channel request is never raised.
// - Master enable neither raises nor masks end requests.
// - Long address write lands as three byte writes; bus may pass between bytes.
// - Full mode, enable 1, master 0: channel halted, its source's CPU interrupt blocked.
// - NMI in full mode drops a unit not acked in that cycle, clears master enable, halts.
// - Block size counter keeps its partial value on a mid-block halt.
// - Mid-block NMI halt clears the activating flag; no request stays pending.
// - While halted by master enable, activations are dropped, not remembered.
// - After master enable returns, next request resumes or starts a block.
// - In 1-Mbyte mode memory address bits 23..20 are ignored.
// - A dead cycle after halt leaves address and counters unchanged.
// - Full mode channel runs only with both enables at 1.
module dmc_top import dmc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Activation sources
	input wire logic nmi,
	input wire logic [NPAIR-1:0] act_req,
	output logic [NPAIR-1:0] act_flag_clr,
	output logic [NPAIR-1:0] src_irq_block,
	// Transfer engine
	output logic [NPAIR-1:0] xfer_req,
	input wire logic [NPAIR-1:0] xfer_ack,
	output logic [NPAIR-1:0][AW-1:0] mem_addr,
	// End of transfer interrupts
	output logic end_irq_ch0_a,
	output logic end_irq_ch0_b,
	output logic end_irq_ch1_a,
	output logic end_irq_ch1_b,
	output logic [1:0] end_irq_top,
	output logic end_irq_any
);

	logic [NCHAN-1:0] dte_v;
	logic [NCHAN-1:0] die_v;
	logic [NPAIR-1:0] full_v;
	logic [NPAIR-1:0] master_transfer_enable_v;
	logic [NPAIR-1:0] step_v;
	logic [NCHAN-1:0] irq_v;
	logic [7:0] ctla_w [NPAIR];
	logic [7:0] ctlb_w [NPAIR];
	logic [AW-1:0] mar_w [NPAIR];
	logic [TCW-1:0] tc_w [NPAIR];
	logic [BSW-1:0] bsz_w [NPAIR];
	logic [BSW-1:0] bszi_w [NPAIR];
	logic mode16_r;
	logic mode16_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// ----------------------------------------
	// Per pair registers and engine
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < NPAIR; p++) begin : g_pair
			dmc_chan_if c ();
			logic [7:0] ca_r;
			logic [7:0] ca_nxt;
			logic [7:0] cb_r;
			logic [7:0] cb_nxt;
			logic [AW-1:0] mar_r;
			logic [AW-1:0] mar_nxt;
			logic [TCW-1:0] tc_r;
			logic [TCW-1:0] tc_nxt;
			logic [BSW-1:0] bsz_r;
			logic [BSW-1:0] bsz_nxt;
			logic [BSW-1:0] bszi_r;
			logic [BSW-1:0] bszi_nxt;
			logic sel;

			assign sel = reg_wr && (reg_addr[7:4] == 4'(p));
			assign c.channel_transfer_enable = ca_r[BIT_DTE];
			assign c.master_transfer_enable = cb_r[BIT_MASTER_TRANSFER_ENABLE];
			assign c.full = ca_r[BIT_FULL];
			assign c.blk = ca_r[BIT_BLK];
			assign c.bsz_first = (bsz_r == bszi_r);
			assign c.bsz_last = (bsz_r == 8'h01);
			assign c.tc_last = (tc_r == 16'h0001);

			dmc_pair u_pair (
				.clock(clock),
				.reset_n(reset_n),
				.act_req(act_req[p]),
				.xfer_ack(xfer_ack[p]),
				.nmi(nmi),
				.c(c.eng)
			);

			always_comb begin
				ca_nxt = ca_r;
				cb_nxt = cb_r;
				mar_nxt = mar_r;
				tc_nxt = tc_r;
				bsz_nxt = bsz_r;
				bszi_nxt = bszi_r;
				if (c.step) begin
					mar_nxt = mar_r + (ca_r[BIT_WORD] ? STEP_WORD : STEP_BYTE);
					if (c.blk && !c.bsz_last) begin
						bsz_nxt = bsz_r - 8'h01;
					end else begin
						bsz_nxt = bszi_r;
						tc_nxt = tc_r - 16'h0001;
					end
				end
				if (c.dte_clr) begin
					ca_nxt[BIT_DTE] = 1'b0;
				end
				// Software writes override the end-of-transfer clear of the same cycle.
				if (sel) begin
					unique case (reg_addr[3:0])
						OFS_CTRL_A: ca_nxt = reg_wdata;
						OFS_CTRL_B: cb_nxt = reg_wdata;
						OFS_MAR_HI: mar_nxt[23:16] = reg_wdata;
						OFS_MAR_MID: mar_nxt[15:8] = reg_wdata;
						OFS_MAR_LO: mar_nxt[7:0] = reg_wdata;
						OFS_TC_HI: tc_nxt[15:8] = reg_wdata;
						OFS_TC_LO: tc_nxt[7:0] = reg_wdata;
						OFS_BSZ_CNT: bsz_nxt = reg_wdata;
						OFS_BSZ_INIT: bszi_nxt = reg_wdata;
						default: begin
						end
					endcase
				end
				// NMI beats a simultaneous software set so the halt is never missed.
				if (c.master_transfer_enable_clr) begin
					cb_nxt[BIT_MASTER_TRANSFER_ENABLE] = 1'b0;
				end
			end

			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					ca_r <= CTRL_RST;
					cb_r <= CTRL_RST;
					mar_r <= MAR_RST;
					tc_r <= TC_RST;
					bsz_r <= BSZ_RST;
					bszi_r <= BSZ_RST;
				end else begin
					ca_r <= ca_nxt;
					cb_r <= cb_nxt;
					mar_r <= mar_nxt;
					tc_r <= tc_nxt;
					bsz_r <= bsz_nxt;
					bszi_r <= bszi_nxt;
				end
			end

			assign ctla_w[p] = ca_r;
			assign ctlb_w[p] = cb_r;
			assign mar_w[p] = mar_r;
			assign tc_w[p] = tc_r;
			assign bsz_w[p] = bsz_r;
			assign bszi_w[p] = bszi_r;
			assign dte_v[2*p] = ca_r[BIT_DTE];
			assign dte_v[2*p+1] = cb_r[BIT_DTE];
			assign die_v[2*p] = ca_r[BIT_DIE];
			assign die_v[2*p+1] = cb_r[BIT_DIE];
			assign full_v[p] = ca_r[BIT_FULL];
			assign master_transfer_enable_v[p] = cb_r[BIT_MASTER_TRANSFER_ENABLE];
			assign step_v[p] = c.step;
			assign xfer_req[p] = c.xfer_req;
			assign act_flag_clr[p] = c.flag_clr;
			assign src_irq_block[p] = c.src_block;
			assign mem_addr[p] = mode16_r ? mar_r : (mar_r & MASK_1M);
		end
	endgenerate

	// ----------------------------------------
	// End of transfer interrupts
	// ----------------------------------------
	dmc_end_irq u_end_irq (
		.channel_transfer_enable(dte_v),
		.die(die_v),
		.full(full_v),
		.irq(irq_v),
		.top(end_irq_top),
		.any(end_irq_any)
	);

	assign end_irq_ch0_a = irq_v[0];
	assign end_irq_ch0_b = irq_v[1];
	assign end_irq_ch1_a = irq_v[2];
	assign end_irq_ch1_b = irq_v[3];

	// ----------------------------------------
	// Global mode and read data
	// ----------------------------------------
	always_comb begin
		mode16_nxt = mode16_r;
		if (reg_wr && (reg_addr == REG_MODE)) begin
			mode16_nxt = reg_wdata[BIT_MODE16M];
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd && (reg_addr[7:4] < 4'(NPAIR))) begin
			unique case (reg_addr[3:0])
				OFS_CTRL_A: rdata_nxt = ctla_w[reg_addr[4]];
				OFS_CTRL_B: rdata_nxt = ctlb_w[reg_addr[4]];
				OFS_MAR_HI: rdata_nxt = mar_w[reg_addr[4]][23:16];
				OFS_MAR_MID: rdata_nxt = mar_w[reg_addr[4]][15:8];
				OFS_MAR_LO: rdata_nxt = mar_w[reg_addr[4]][7:0];
				OFS_TC_HI: rdata_nxt = tc_w[reg_addr[4]][15:8];
				OFS_TC_LO: rdata_nxt = tc_w[reg_addr[4]][7:0];
				OFS_BSZ_CNT: rdata_nxt = bsz_w[reg_addr[4]];
				OFS_BSZ_INIT: rdata_nxt = bszi_w[reg_addr[4]];
				default: rdata_nxt = 8'h00;
			endcase
		end else if (reg_rd && (reg_addr == REG_MODE)) begin
			rdata_nxt = {7'h00, mode16_r};
		end else if (reg_rd && (reg_addr == REG_IRQ_STAT)) begin
			rdata_nxt = {1'b0, end_irq_any, end_irq_top, irq_v};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode16_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			mode16_r <= mode16_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_end_on_done: assert property (
		@(posedge clock) disable iff (!reset_n)
		$fell(dte_v[2]) && die_v[2] |-> end_irq_ch1_a && end_irq_any
	) else $error("end request missing after transfer end");

	chk_b_silent_full: assert property (
		@(posedge clock) disable iff (!reset_n)
		!(full_v[0] && end_irq_ch0_b) && !(full_v[1] && end_irq_ch1_b)
	) else $error("B channel end request in full mode");

	chk_irq_priority: assert property (
		@(posedge clock) disable iff (!reset_n)
		end_irq_ch1_a && !end_irq_ch0_a && !end_irq_ch0_b |-> end_irq_top == 2'h2
	) else $error("wrong end request priority");

	chk_master_blind: assert property (
		@(posedge clock) disable iff (!reset_n)
		$changed(master_transfer_enable_v[0]) && $stable(dte_v[0]) && $stable(die_v[0]) |-> $stable(end_irq_ch0_a)
	) else $error("master enable moved an end request");

	chk_irq_level: assert property (
		@(posedge clock) disable iff (!reset_n)
		end_irq_ch1_a && !reg_wr |=> end_irq_ch1_a
	) else $error("end request dropped without software");

	chk_nmi_halt: assert property (
		@(posedge clock) disable iff (!reset_n)
		nmi && full_v[1] && master_transfer_enable_v[1] |=> !master_transfer_enable_v[1] && !xfer_req[1]
	) else $error("NMI did not halt full mode pair");

	chk_addr_frozen: assert property (
		@(posedge clock) disable iff (!reset_n)
		!step_v[0] && !reg_wr |=> $stable(mar_w[0]) && $stable(bsz_w[0]) && $stable(tc_w[0])
	) else $error("address or counter moved without a step");

	chk_flag_drop: assert property (
		@(posedge clock) disable iff (!reset_n)
		act_flag_clr[1] |=> !xfer_req[1] [*2]
	) else $error("request kept after mid-block halt");

	chk_halt_ignore: assert property (
		@(posedge clock) disable iff (!reset_n)
		src_irq_block[1] && act_req[1] && !xfer_req[1] ##1 !reg_wr |-> !xfer_req[1]
	) else $error("activation remembered while halted");

	chk_src_blocked: assert property (
		@(posedge clock) disable iff (!reset_n)
		full_v[0] && dte_v[0] && !master_transfer_enable_v[0] |-> src_irq_block[0] && !xfer_req[0]
	) else $error("source not blocked while halted");

	chk_both_enables: assert property (
		@(posedge clock) disable iff (!reset_n)
		xfer_req[1] |-> dte_v[2] && master_transfer_enable_v[1] && full_v[1]
	) else $error("transfer requested without both enables");

	chk_resume_req: assert property (
		@(posedge clock) disable iff (!reset_n)
		full_v[0] && dte_v[0] && master_transfer_enable_v[0] && act_req[0] && !nmi && !reg_wr |=> xfer_req[0]
	) else $error("no transfer after request while enabled");

	chk_addr_1m: assert property (
		@(posedge clock) disable iff (!reset_n)
		!mode16_r |-> mem_addr[0][23:20] == 4'h0 && mem_addr[1][23:20] == 4'h0
	) else $error("high address bits leak in 1-Mbyte mode");

	chk_partial_kept: assert property (
		@(posedge clock) disable iff (!reset_n)
		nmi && xfer_req[1] && !xfer_ack[1] && !reg_wr |=> $stable(bsz_w[1])
	) else $error("block counter lost on halt");

endmodule : dmc_top
